// *** fwsr_flash_model.sv ***
`timescale 1ns/1ps
// Flash device behaviour as seen from its pins; the bench arms each operation
module fwsr_flash_model
(
  input  wire logic       chipSelN,
  input  wire logic       outEnN,
  input  wire logic       writeStrobeN,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataBus,
  output logic            readyBusy
);
  import fwsr_pkg::*;

  localparam logic [7:0] ARRAY_BYTE = 8'h5a;

  logic       busy;
  logic       eraseMode;
  logic       tmo;
  logic       togOne;
  logic       togTwo;
  logic [7:0] datum;
  logic [7:0] held;
  logic [7:0] lastWrite;
  int         readsLeft;
  int         resetSeen;
  wire        rdOn = !chipSelN && !outEnN;
  wire  [7:0] status = {eraseMode ? 1'b0 : ~datum[7], togOne, tmo, 1'b0,
                        eraseMode, eraseMode & togTwo, 2'b00};
  wire  [7:0] cur = busy ? status : ARRAY_BYTE;

  initial
  begin
    busy = 1'b0;
    eraseMode = 1'b0;
    tmo = 1'b0;
    datum = 8'h00;
    held = 8'h00;
    lastWrite = 8'h00;
    resetSeen = 0;
  end

  // Starts an operation as if its last write strobe just ended; reads < 0 never ends
  task automatic arm(input logic erase, input int reads, input logic flag, input logic [7:0] d);
    busy = 1'b1;
    eraseMode = erase;
    readsLeft = reads;
    tmo = flag;
    datum = d;
    togOne = 1'b0;
    togTwo = 1'b0;
  endtask : arm

  // End of a read cycle, by either strobe
  always @(negedge rdOn)
    if (busy)
    begin
      togOne = ~togOne;
      togTwo = ~togTwo;
      if (readsLeft > 0)
        readsLeft--;
      if (readsLeft == 0)
        busy = 1'b0;
    end

  // Every completed write cycle leaves its byte here for the bench
  always @(posedge writeStrobeN)
    if (!chipSelN)
      lastWrite = dataIn;

  // Only the reset command after a timing failure is obeyed while busy
  always @(posedge writeStrobeN)
    if (!chipSelN && dataIn === FWSR_RESET_CMD && (tmo || !busy))
    begin
      busy = 1'b0;
      resetSeen++;
    end

  // Released bus shows the inverse of the last byte, never a kind guess
  always @*
    if (rdOn)
      held = cur;
  assign dataBus = rdOn ? cur : ~held;
  assign readyBusy = ~busy;
endmodule : fwsr_flash_model

// *** fwsr_host.sv ***
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module fwsr_host
  import fwsr_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output fwsr_pkg::fwsr_pins_t      flashPins,
  input  wire logic [7:0]           flashDataIn,
  input  wire logic                 readyBusyIn
);
  import fwsr_pkg::*;

  fwsr_state_t      state_q;
  logic [21:0]      addr_q;
  logic [7:0]       wdata_q;
  logic [7:0]       first_q;
  logic [7:0]       second_q;
  logic [7:0]       rdata_q;
  logic [1:0]       result_q;
  logic             busy_q;
  logic             timerSeen_q;
  logic [7:0]       cnt_q;
  logic [1:0]       phase_q;
  logic [7:0]       dinMeta_q;
  logic [7:0]       dinSync_q;
  logic             rbMeta_q;
  logic             rbSync_q;
  logic             pwStart;
  logic             strobeDone;
  logic             toggling;
  logic [7:0]       capt_q;
  logic             sampleNow;

  // Two-stage sync of pins from the asynchronous flash
  always_ff @(posedge mclk)
  begin
    dinMeta_q <= flashDataIn;
    dinSync_q <= dinMeta_q;
    rbMeta_q  <= readyBusyIn;
    rbSync_q  <= rbMeta_q;
  end

  // Toggle detect on either status toggle bit
  function automatic logic fwsr_toggled(input logic [7:0] a, input logic [7:0] b);
    fwsr_toggled = (a[FWSR_TOGONE_POS] != b[FWSR_TOGONE_POS])
                || (a[FWSR_TOGTWO_POS] != b[FWSR_TOGTWO_POS]);
  endfunction : fwsr_toggled

  assign toggling   = fwsr_toggled(first_q, second_q);
  assign pwStart    = psel && penable && pwrite && pready;
  assign strobeDone = (cnt_q == 8'(FWSR_STROBE_CYC)) && (phase_q == 2'h2);
  assign sampleNow  = (cnt_q == 8'(FWSR_STROBE_CYC)) && (phase_q == 2'h1);

  // APB slave answers in the second access cycle; pready pulses one cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= FWSR_REG_RESET;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      unique case (paddr)
        FWSR_ADDR_OFF:   prdata <= {10'h000, addr_q};
        FWSR_DATA_OFF:   prdata <= {24'h000000, wdata_q};
        FWSR_STATUS_OFF: prdata <= {27'h0, timerSeen_q, rbSync_q, result_q, busy_q};
        FWSR_RDATA_OFF:  prdata <= {24'h000000, rdata_q};
        default:         prdata <= FWSR_REG_RESET;
      endcase
    end
  end

  // Address and write data registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      addr_q  <= 22'h000000;
      wdata_q <= 8'h00;
    end
    else if (pwStart && paddr == FWSR_ADDR_OFF && !busy_q)
      addr_q <= pwdata[21:0];
    else if (pwStart && paddr == FWSR_DATA_OFF && !busy_q)
      wdata_q <= pwdata[7:0];
  end

  // Bus cycle timer: phase 0 setup, 1 strobe low, 2 recovery
  always_ff @(posedge mclk)
  begin
    if (reset || state_q == FWSR_IDLE || state_q == FWSR_EVAL || state_q == FWSR_EVAL2)
    begin
      cnt_q   <= 8'h00;
      phase_q <= 2'h0;
    end
    else if (cnt_q == 8'(FWSR_STROBE_CYC))
    begin
      cnt_q   <= 8'h00;
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // Data taken as the strobe-low phase ends; once the strobe rises the bus shows the inverse of the last byte
  always_ff @(posedge mclk)
  begin
    if (reset)
      capt_q <= 8'h00;
    else if (sampleNow)
      capt_q <= dinSync_q;
  end

  // Sequencer: each read is a full separate OE cycle so the toggle bits advance
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q     <= FWSR_IDLE;
      busy_q      <= 1'b0;
      result_q    <= FWSR_RES_NONE;
      first_q     <= 8'h00;
      second_q    <= 8'h00;
      rdata_q     <= 8'h00;
      timerSeen_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        FWSR_IDLE:
        begin
          if (pwStart && paddr == FWSR_CTRL_OFF)
          begin
            busy_q <= 1'b1;
            if (pwdata[FWSR_CTRL_POLL_POS])
            begin
              state_q  <= FWSR_RD1;
              result_q <= FWSR_RES_NONE;
            end
            else if (pwdata[FWSR_CTRL_WRITE_POS])
              state_q <= FWSR_WR;
            else if (pwdata[FWSR_CTRL_READ_POS])
              state_q <= FWSR_RDARR;
            else if (pwdata[FWSR_CTRL_ARST_POS])
              state_q <= FWSR_FAILWR;
            else
              busy_q <= 1'b0;
          end
        end
        FWSR_RD1:
          if (strobeDone)
          begin
            first_q <= capt_q;
            state_q <= FWSR_RD2;
          end
        FWSR_RD2:
          if (strobeDone)
          begin
            second_q <= capt_q;
            state_q  <= FWSR_EVAL;
          end
        FWSR_EVAL:
        begin
          timerSeen_q <= second_q[FWSR_ETIMER_POS];
          if (!toggling)
            state_q <= FWSR_RDARR;
          else if (second_q[FWSR_TIMEOUT_POS])
            state_q <= FWSR_RD3;
          else
            state_q <= FWSR_RD1;
        end
        FWSR_RD3:
          if (strobeDone)
          begin
            first_q <= capt_q;
            state_q <= FWSR_RD4;
          end
        FWSR_RD4:
          if (strobeDone)
          begin
            second_q <= capt_q;
            state_q  <= FWSR_EVAL2;
          end
        FWSR_EVAL2:
          if (!toggling)
            state_q <= FWSR_RDARR;
          else
          begin
            result_q <= FWSR_RES_FAIL;
            state_q  <= FWSR_FAILWR;
          end
        FWSR_WR:
          if (strobeDone)
          begin
            busy_q  <= 1'b0;
            state_q <= FWSR_IDLE;
          end
        FWSR_RDARR:
          if (strobeDone)
          begin
            rdata_q  <= capt_q;
            busy_q   <= 1'b0;
            if (result_q == FWSR_RES_NONE)
              result_q <= FWSR_RES_DONE;
            state_q  <= FWSR_IDLE;
          end
        FWSR_FAILWR:
          if (strobeDone)
          begin
            busy_q  <= 1'b0;
            state_q <= FWSR_IDLE;
          end
        default:
          state_q <= FWSR_IDLE;
      endcase
    end
  end

  // Pin drive from state and phase; strobes low only in phase 1
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      flashPins <= '{chipSelN: 1'b1, outEnN: 1'b1, writeStrobeN: 1'b1,
                     addr: 22'h000000, dataOut: 8'h00, dataOe: 1'b0};
    end
    else
    begin
      flashPins.addr     <= addr_q;
      flashPins.chipSelN <= (state_q == FWSR_IDLE || state_q == FWSR_EVAL
                             || state_q == FWSR_EVAL2);
      flashPins.outEnN   <= !(phase_q == 2'h1 && (state_q == FWSR_RD1 || state_q == FWSR_RD2
                             || state_q == FWSR_RD3 || state_q == FWSR_RD4
                             || state_q == FWSR_RDARR));
      flashPins.writeStrobeN <= !(phase_q == 2'h1 && (state_q == FWSR_WR
                                 || state_q == FWSR_FAILWR));
      flashPins.dataOe  <= (state_q == FWSR_WR || state_q == FWSR_FAILWR);
      flashPins.dataOut <= (state_q == FWSR_FAILWR) ? FWSR_RESET_CMD : wdata_q;
    end
  end

  // Checks on the pin and state sequencing and on the result code
  a_no_both_strobes: assert property (@(posedge mclk) disable iff (reset)
    !(!flashPins.outEnN && !flashPins.writeStrobeN))
    else $error("read and write strobes low together");
  a_fail_resets: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_EVAL2 && toggling) |=> state_q == FWSR_FAILWR)
    else $error("failure not followed by reset command");
  a_recheck_timeout: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_EVAL && toggling && second_q[FWSR_TIMEOUT_POS]) |=> state_q == FWSR_RD3)
    else $error("timeout flag did not force recheck");
  a_done_array: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_EVAL && !toggling) |=> state_q == FWSR_RDARR)
    else $error("stable toggle did not lead to array read");
  a_two_reads: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_RD1 && strobeDone) |=> state_q == FWSR_RD2)
    else $error("first read not followed by second");
  a_poll_restart: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_IDLE && pwStart && paddr == FWSR_CTRL_OFF && pwdata[0])
    |=> state_q == FWSR_RD1)
    else $error("poll start skipped first read");
  a_reset_cmd: assert property (@(posedge mclk) disable iff (reset)
    (!flashPins.writeStrobeN && $past(state_q) == FWSR_FAILWR)
    |-> flashPins.dataOut == FWSR_RESET_CMD)
    else $error("reset command byte wrong");
  a_fail_result: assert property (@(posedge mclk) disable iff (reset)
    (state_q == FWSR_EVAL2 && toggling) |=> result_q == FWSR_RES_FAIL)
    else $error("failure not reported");
  a_sample_strobe: assert property (@(posedge mclk) disable iff (reset)
    (sampleNow && state_q inside {FWSR_RD1, FWSR_RD2, FWSR_RD3, FWSR_RD4, FWSR_RDARR})
    |-> !flashPins.outEnN)
    else $error("read data taken outside the strobe");
  c_done: cover property (@(posedge mclk) state_q == FWSR_RDARR && result_q == FWSR_RES_NONE);
  c_write: cover property (@(posedge mclk) state_q == FWSR_WR && strobeDone);
  c_fail: cover property (@(posedge mclk) state_q == FWSR_FAILWR && result_q == FWSR_RES_FAIL);
  c_repoll: cover property (@(posedge mclk) state_q == FWSR_EVAL ##1 state_q == FWSR_RD1);

endmodule : fwsr_host

// *** fwsr_pkg.sv ***
package fwsr_pkg;

  // Register byte offsets on the APB side
  localparam logic [11:0] FWSR_CTRL_OFF   = 12'h000;
  localparam logic [11:0] FWSR_ADDR_OFF   = 12'h004;
  localparam logic [11:0] FWSR_DATA_OFF   = 12'h008;
  localparam logic [11:0] FWSR_STATUS_OFF = 12'h00c;
  localparam logic [11:0] FWSR_RDATA_OFF  = 12'h010;

  // Control field positions
  localparam int FWSR_CTRL_POLL_POS  = 0;
  localparam int FWSR_CTRL_WRITE_POS = 1;
  localparam int FWSR_CTRL_READ_POS  = 2;
  localparam int FWSR_CTRL_ARST_POS  = 3;

  // Status bit positions in the flash data byte
  localparam int FWSR_POLL_POS    = 7;
  localparam int FWSR_TOGONE_POS  = 6;
  localparam int FWSR_TIMEOUT_POS = 5;
  localparam int FWSR_ETIMER_POS  = 3;
  localparam int FWSR_TOGTWO_POS  = 2;

  // Result codes
  localparam logic [1:0] FWSR_RES_NONE = 2'h0;
  localparam logic [1:0] FWSR_RES_DONE = 2'h1;
  localparam logic [1:0] FWSR_RES_FAIL = 2'h2;

  // Reset command written after a timing-limit failure
  localparam logic [7:0]  FWSR_RESET_CMD = 8'hf0;
  localparam logic [31:0] FWSR_REG_RESET = 32'h0000_0000;

  // Bus cycle timing
  localparam int FWSR_CLK_MHZ      = 50;
  localparam int FWSR_STROBE_NS    = 100;
  localparam int FWSR_STROBE_CYC   = (FWSR_STROBE_NS * FWSR_CLK_MHZ + 999) / 1000;
  localparam int FWSR_SECT_WIN_US  = 50;
  localparam int FWSR_SECT_WIN_CYC = FWSR_SECT_WIN_US * FWSR_CLK_MHZ;

  // Flash pin group driven by the host
  typedef struct packed {
    logic        chipSelN;
    logic        outEnN;
    logic        writeStrobeN;
    logic [21:0] addr;
    logic [7:0]  dataOut;
    logic        dataOe;
  } fwsr_pins_t;

  typedef enum logic [3:0] {
    FWSR_IDLE   = 4'h0,
    FWSR_RD1    = 4'h1,
    FWSR_RD2    = 4'h2,
    FWSR_EVAL   = 4'h3,
    FWSR_RD3    = 4'h4,
    FWSR_RD4    = 4'h5,
    FWSR_EVAL2  = 4'h6,
    FWSR_WR     = 4'h7,
    FWSR_RDARR  = 4'h8,
    FWSR_FAILWR = 4'h9
  } fwsr_state_t;

endpackage : fwsr_pkg

// *** tb_flash_write_status_reporting.sv ***
`timescale 1ns/1ps
module tb_flash_write_status_reporting;
  import fwsr_pkg::*;

  logic        mclk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] st;
  logic        pready;
  logic        pslverr;
  logic        rdErr;
  fwsr_pins_t  pins;
  logic [7:0]  flashData;
  logic        readyBusy;
  wire  [7:0]  dq = pins.dataOe ? pins.dataOut : flashData;
  int          fail_count;
  int          tests_run;
  int          cyc;

  fwsr_host DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashPins(pins), .flashDataIn(dq), .readyBusyIn(readyBusy));

  fwsr_flash_model FLASH (.chipSelN(pins.chipSelN), .outEnN(pins.outEnN),
    .writeStrobeN(pins.writeStrobeN), .dataIn(dq), .dataBus(flashData), .readyBusy(readyBusy));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard, far above the several hundred cycles the tests need
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      $display("BAD run_length expected finish seen hang");
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // One APB transfer; read data kept in rd
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Starts one controller operation and waits for the busy flag to drop
  task automatic op(input logic [31:0] ctrl);
    apb(1'b1, FWSR_CTRL_OFF, ctrl);
    repeat (300)
    begin
      apb(1'b0, FWSR_STATUS_OFF, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    st = rd;
  endtask : op

  // Arms the flash, starts a poll and waits for the busy flag to drop
  task automatic poll(input int reads, input logic erase, input logic flag);
    FLASH.arm(erase, reads, flag, 8'h33);
    apb(1'b1, FWSR_ADDR_OFF, 32'h0001_2345);
    op(32'h1 << FWSR_CTRL_POLL_POS);
  endtask : poll

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, FWSR_RDATA_OFF, 32'h0);
    chk("rdata_reset", FWSR_REG_RESET, rd);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped_read", 32'h0, rd);
    chk("unmapped_err", 32'h0, rdErr);
    $display("test registers done");
    // Plain write cycle and plain array read, ordered through the control register
    apb(1'b1, FWSR_DATA_OFF, 32'h0000_00a5);
    apb(1'b0, FWSR_DATA_OFF, 32'h0);
    chk("data_reg", 32'ha5, rd);
    op(32'h1 << FWSR_CTRL_WRITE_POS);
    chk("write_byte", 32'ha5, FLASH.lastWrite);
    op(32'h1 << FWSR_CTRL_READ_POS);
    chk("read_result", FWSR_RES_DONE, st[2:1]);
    apb(1'b0, FWSR_RDATA_OFF, 32'h0);
    chk("read_array", 32'h5a, rd[7:0]);
    $display("test write_read done");
    // Program keeps toggling for a while, then finishes cleanly
    poll(5, 1'b0, 1'b0);
    chk("prog_result", FWSR_RES_DONE, st[2:1]);
    chk("prog_ready", 32'h1, st[3]);
    chk("pin_addr", 32'h0001_2345, pins.addr);
    apb(1'b0, FWSR_ADDR_OFF, 32'h0);
    chk("addr_reg", 32'h0001_2345, rd);
    apb(1'b0, FWSR_RDATA_OFF, 32'h0);
    chk("prog_array", 32'h5a, rd[7:0]);
    $display("test program done");
    // Erase stops toggling just as the flag rises: recheck gives success
    poll(2, 1'b1, 1'b1);
    chk("erase_late_result", FWSR_RES_DONE, st[2:1]);
    chk("erase_timer", 32'h1, st[4]);
    $display("test erase_late done");
    // Erase still toggling with flag high: failure and reset command
    poll(-1, 1'b1, 1'b1);
    chk("erase_fail_result", FWSR_RES_FAIL, st[2:1]);
    chk("erase_fail_reset", 32'h1, FLASH.resetSeen);
    $display("test erase_fail done");
    // Program of one over zero halts and flags
    poll(-1, 1'b0, 1'b1);
    chk("prog_fail_result", FWSR_RES_FAIL, st[2:1]);
    chk("prog_fail_reset", 32'h2, FLASH.resetSeen);
    $display("test prog_fail done");
    // Reset command ordered directly by software on an idle bank
    op(32'h1 << FWSR_CTRL_ARST_POS);
    chk("bare_reset", 32'h3, FLASH.resetSeen);
    chk("bare_reset_byte", FWSR_RESET_CMD, FLASH.lastWrite);
    $display("test bare_reset done");
    wrap_up();
  end
endmodule : tb_flash_write_status_reporting
